//--- shared/csl_pkg.sv
`default_nettype none
package csl_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    // control fields
    localparam int CTRL_MODCLR_BIT = 0;
    localparam int CTRL_VARIANT_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    // status fields
    localparam int ST_RUN_LED_BIT = 0;
    localparam int ST_ERR_LED_BIT = 1;
    localparam int ST_INIT_BIT = 2;
    localparam int ST_MODFLT_BIT = 3;
    localparam int ST_BOOTFAIL_BIT = 4;
    localparam int ST_ERRSEL_LSB = 8;
    // interrupt event bits
    localparam int IRQ_MODFLT_BIT = 0;
    localparam int IRQ_BUSOFF_BIT = 1;
    localparam int IRQ_SYNC_BIT = 2;
    localparam int IRQ_GUARD_BIT = 3;
    localparam int IRQ_WARN_BIT = 4;
    localparam int IRQ_W = 5;
    // nmt state encoding
    localparam logic [1:0] NMT_STOPPED = 2'h0;
    localparam logic [1:0] NMT_PREOP = 2'h1;
    localparam logic [1:0] NMT_OPER = 2'h2;
    // switch encodings
    localparam logic [3:0] BAUD_INIT = 4'h9;
    localparam logic [3:0] BAUD_MAX = 4'h7;
    localparam logic [7:0] NODE_ZERO = 8'h00;
    localparam logic [7:0] NODE_PAIR_ZERO = 8'h80;
    // flash timing
    localparam int CLK_HZ = 125_000_000;
    localparam int PHASE_MS = 200;
    localparam int RAPID_MS = 50;
    localparam int GAP_MS = 1000;
    localparam int PHASE_CYC = CLK_HZ / 1000 * PHASE_MS;
    localparam int RAPID_CYC = CLK_HZ / 1000 * RAPID_MS;
    localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
    // pattern selectors
    typedef enum logic [2:0] {
        PAT_OFF, PAT_ON, PAT_SINGLE, PAT_DOUBLE, PAT_TRIPLE, PAT_BLINK,
        PAT_RAPID
    } csl_pat_t;
endpackage : csl_pkg
`default_nettype wire

//--- rtl/csl_flasher.sv
`default_nettype none
// turns a pattern selector into an led level; flash counts restart
// cleanly whenever the selector changes so no half pattern is shown
module csl_flasher #(
    parameter int PHASE_CYC = csl_pkg::PHASE_CYC,
    parameter int RAPID_CYC = csl_pkg::RAPID_CYC,
    parameter int GAP_CYC = csl_pkg::GAP_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // pattern in, level out
    input wire csl_pkg::csl_pat_t pat,
    output logic led
);
    logic [31:0] tmr_r;
    logic [2:0] step_r;
    csl_pkg::csl_pat_t pat_r;
    logic [2:0] flashes;
    logic [31:0] dur;

    // number of flashes for counted patterns
    always_comb begin
        case (pat)
            csl_pkg::PAT_SINGLE: flashes = 3'h1;
            csl_pkg::PAT_DOUBLE: flashes = 3'h2;
            csl_pkg::PAT_TRIPLE: flashes = 3'h3;
            default: flashes = 3'h0;
        endcase
    end

    // length of current phase; last off phase of a burst is the long gap
    always_comb begin
        if (pat == csl_pkg::PAT_RAPID)
            dur = 32'(RAPID_CYC);
        else if (flashes != 3'h0 && step_r == 3'(2 * flashes - 1))
            dur = 32'(GAP_CYC);
        else
            dur = 32'(PHASE_CYC);
    end

    // phase timer and step counter
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tmr_r <= 32'h0000_0000;
            step_r <= 3'h0;
            pat_r <= csl_pkg::PAT_OFF;
            led <= 1'b0;
        end else begin
            pat_r <= pat;
            if (pat != pat_r) begin
                tmr_r <= 32'h0000_0000;
                step_r <= 3'h0;
            end else if (tmr_r >= dur - 32'h0000_0001) begin
                tmr_r <= 32'h0000_0000;
                if (flashes != 3'h0 && step_r == 3'(2 * flashes - 1))
                    step_r <= 3'h0;
                else if (flashes == 3'h0)
                    step_r <= {2'h0, ~step_r[0]};
                else
                    step_r <= step_r + 3'h1;
            end else begin
                tmr_r <= tmr_r + 32'h0000_0001;
            end
            case (pat)
                csl_pkg::PAT_OFF: led <= 1'b0;
                csl_pkg::PAT_ON: led <= 1'b1;
                default: led <= (pat == pat_r) && !step_r[0];
            endcase
        end
    end
endmodule : csl_flasher
`default_nettype wire

//--- rtl/csl_status_led.sv
// Added by the designer: the AXI4-Lite register port and the register addresses.
`default_nettype none
module csl_status_led #(
    parameter int PHASE_CYC = csl_pkg::PHASE_CYC,
    parameter int RAPID_CYC = csl_pkg::RAPID_CYC,
    parameter int GAP_CYC = csl_pkg::GAP_CYC,
    parameter int BOOT_DLY = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // protocol stack and can controller status, same clock
    input wire logic node_ready,
    input wire logic [1:0] nmt_state,
    input wire logic module_fault,
    input wire logic can_warn,
    input wire logic can_bus_off,
    input wire logic guard_event,
    input wire logic sync_timeout,
    // switch pins, asynchronous
    input wire logic [3:0] baud_selector,
    input wire logic [7:0] node_id_selector,
    input wire logic init_run_selector,
    // outputs
    output logic run_led,
    output logic err_led,
    output logic init_mode,
    output logic boot_fail,
    output logic irq
);
    // switch synchronisers: three stages, accept when stages 2 and 3 agree
    logic [12:0] sw_s1_r, sw_s2_r, sw_s3_r, sw_r;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sw_s1_r <= 13'h0000;
            sw_s2_r <= 13'h0000;
            sw_s3_r <= 13'h0000;
            sw_r <= 13'h0000;
        end else begin
            sw_s1_r <= {init_run_selector, node_id_selector, baud_selector};
            sw_s2_r <= sw_s1_r;
            sw_s3_r <= sw_s2_r;
            if (sw_s2_r == sw_s3_r)
                sw_r <= sw_s3_r;
        end
    end

    // control register and module-fault latch
    localparam int IRQ_W_L = csl_pkg::IRQ_W;
    logic [31:0] ctrl_r, mask_r;
    logic [IRQ_W_L-1:0] irq_stat_r;
    logic modflt_r;
    logic wr_fire;
    logic [7:0] aw_r;
    logic [31:0] w_r;
    logic [3:0] ws_r;
    logic aw_ok_r, w_ok_r;
    logic rd_clr;

    // strobe-aware merge of a write into a word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        return r;
    endfunction : merge

    // latched until software writes the clear bit; set wins over clear
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            modflt_r <= 1'b0;
        else if (module_fault)
            modflt_r <= 1'b1;
        else if (wr_fire && aw_r == csl_pkg::CTRL_OFS && ws_r[0]
                 && w_r[csl_pkg::CTRL_MODCLR_BIT])
            modflt_r <= 1'b0;
    end

    // start-up switch check and mode selection after a settle delay
    logic [7:0] boot_cnt_r;
    logic booted_r;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            boot_cnt_r <= 8'h00;
            booted_r <= 1'b0;
            boot_fail <= 1'b0;
            init_mode <= 1'b0;
        end else if (!booted_r) begin
            if (boot_cnt_r == 8'(BOOT_DLY)) begin
                booted_r <= 1'b1;
                // node id 0 or 0x80 and baud 8 or above 9 illegal
                boot_fail <= (sw_r[11:4] == csl_pkg::NODE_ZERO)
                    || (sw_r[11:4] == csl_pkg::NODE_PAIR_ZERO)
                    || (sw_r[3:0] > csl_pkg::BAUD_MAX
                        && sw_r[3:0] != csl_pkg::BAUD_INIT);
            end else begin
                boot_cnt_r <= boot_cnt_r + 8'h01;
            end
        end else begin
            // eight-slot uses its own switch, four-slot baud 9
            if (ctrl_r[csl_pkg::CTRL_VARIANT_BIT])
                init_mode <= sw_r[12];
            else
                init_mode <= (sw_r[3:0] == csl_pkg::BAUD_INIT);
        end
    end

    // run led pattern selection
    csl_pkg::csl_pat_t run_pat, err_pat;
    logic running;
    assign running = node_ready && booted_r && !boot_fail && !init_mode;
    always_comb begin
        if (!running)
            run_pat = csl_pkg::PAT_OFF;
        else if (modflt_r)
            run_pat = csl_pkg::PAT_RAPID;
        else begin
            case (nmt_state)
                csl_pkg::NMT_STOPPED: run_pat = csl_pkg::PAT_SINGLE;
                csl_pkg::NMT_PREOP: run_pat = csl_pkg::PAT_BLINK;
                csl_pkg::NMT_OPER: run_pat = csl_pkg::PAT_ON;
                default: run_pat = csl_pkg::PAT_OFF;
            endcase
        end
    end

    // error led: most severe active condition wins
    always_comb begin
        if (can_bus_off)
            err_pat = csl_pkg::PAT_ON;
        else if (sync_timeout)
            err_pat = csl_pkg::PAT_TRIPLE;
        else if (guard_event)
            err_pat = csl_pkg::PAT_DOUBLE;
        else if (can_warn)
            err_pat = csl_pkg::PAT_SINGLE;
        else
            err_pat = csl_pkg::PAT_OFF;
    end

    // two independent flashers
    csl_flasher #(.PHASE_CYC(PHASE_CYC), .RAPID_CYC(RAPID_CYC),
                  .GAP_CYC(GAP_CYC)) u_run (
        .clock(clock), .arst_n(arst_n), .pat(run_pat), .led(run_led));
    csl_flasher #(.PHASE_CYC(PHASE_CYC), .RAPID_CYC(RAPID_CYC),
                  .GAP_CYC(GAP_CYC)) u_err (
        .clock(clock), .arst_n(arst_n), .pat(err_pat), .led(err_led));

    // write channel: address and data in either order, then response
    assign wr_fire = aw_ok_r && w_ok_r && !s_axi_bvalid;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            aw_r <= 8'h00;
            w_r <= 32'h0000_0000;
            ws_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_ok_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_ok_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_r <= 1'b1;
                aw_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_r <= 1'b1;
                w_r <= s_axi_wdata;
                ws_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_ok_r <= 1'b0;
                w_ok_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_r == csl_pkg::CTRL_OFS
                    || aw_r == csl_pkg::IRQ_MASK_OFS
                    || aw_r == csl_pkg::STATUS_OFS
                    || aw_r == csl_pkg::IRQ_STAT_OFS) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // writable registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= csl_pkg::CTRL_RESET;
            mask_r <= csl_pkg::MASK_RESET;
        end else if (wr_fire) begin
            if (aw_r == csl_pkg::CTRL_OFS)
                ctrl_r <= merge(ctrl_r, w_r, ws_r) & 32'h0000_0002;
            if (aw_r == csl_pkg::IRQ_MASK_OFS)
                mask_r <= merge(mask_r, w_r, ws_r) & 32'h0000_001F;
        end
    end

    // sticky events; a read clears, but a new event in that cycle stays
    logic [IRQ_W_L-1:0] ev;
    assign ev = {can_warn, guard_event, sync_timeout, can_bus_off,
                 module_fault};
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            irq_stat_r <= '0;
        else
            irq_stat_r <= (rd_clr ? '0 : irq_stat_r) | ev;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_r & mask_r[IRQ_W_L-1:0]);
    end

    // read channel: one-cycle arready, data the next cycle
    logic [31:0] stat_w;
    assign stat_w = {21'h0, err_pat, 3'h0, boot_fail, modflt_r, init_mode,
                     err_led, run_led};
    assign rd_clr = s_axi_arvalid && s_axi_arready
                    && s_axi_araddr == csl_pkg::IRQ_STAT_OFS;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                             && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    csl_pkg::CTRL_OFS: s_axi_rdata <= ctrl_r;
                    csl_pkg::STATUS_OFS: s_axi_rdata <= stat_w;
                    csl_pkg::IRQ_STAT_OFS:
                        s_axi_rdata <= {27'h0, irq_stat_r};
                    csl_pkg::IRQ_MASK_OFS: s_axi_rdata <= mask_r;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : csl_status_led
`default_nettype wire

//--- dv/csl_led_watch.sv
`default_nettype none
// watches one indicator the way an operator would: lit and dark spells
module csl_led_watch #(
    parameter int PHASE_CYC = 4
) (
    // sampling
    input wire logic clock,
    input wire logic clr,
    input wire logic led,
    // measurements
    output logic [15:0] run_on,
    output logic [15:0] run_off,
    output logic [15:0] on_len,
    output logic [15:0] off_len,
    output logic [3:0] burst
);
    timeunit 1ns;
    timeprecision 1ps;
    logic led_q;
    logic [3:0] pcnt;
    // a flash counts as soon as it lights up
    always_ff @(posedge clock) begin
        if (clr) begin
            {run_on, run_off, on_len, off_len, burst, pcnt, led_q} <= '0;
        end else if (led) begin
            run_on <= run_on + 16'h0001;
            run_off <= 16'h0000;
            if (!led_q) begin
                off_len <= run_off;
                if (run_off > 16'(PHASE_CYC)) begin // long gap ends burst
                    burst <= pcnt;
                    pcnt <= 4'h1;
                end else begin
                    pcnt <= pcnt + 4'h1;
                end
            end
            led_q <= 1'b1;
        end else begin
            run_off <= run_off + 16'h0001;
            run_on <= 16'h0000;
            if (led_q) on_len <= run_on;
            led_q <= 1'b0;
        end
    end
endmodule : csl_led_watch
`default_nettype wire

//--- dv/csl_status_led_asserts.sv
`default_nettype none
module csl_status_led_asserts #(
    parameter int PHASE_CYC = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // status and leds
    input wire logic node_ready,
    input wire logic can_warn,
    input wire logic can_bus_off,
    input wire logic guard_event,
    input wire logic sync_timeout,
    input wire logic run_led,
    input wire logic err_led
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic [7:0] on_cnt_r;
    // length of the current lit spell of the error led
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) on_cnt_r <= 8'h00;
        else on_cnt_r <= err_led ? on_cnt_r + 8'h01 : 8'h00;
    end
    a_run_dark: assert property (
        (!node_ready) [*4] |-> !run_led) else $error("run led lit");
    a_err_dark: assert property (
        (!can_warn && !can_bus_off && !guard_event && !sync_timeout) [*4]
        |-> !err_led) else $error("error led lit without error");
    a_err_busoff: assert property (
        can_bus_off [*4] |-> err_led) else $error("bus-off led dark");
    a_err_phase: assert property (
        (!can_bus_off) [*8] |-> on_cnt_r <= 8'(PHASE_CYC))
        else $error("error flash too long");
    a_rd_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_wr_latency: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    a_bad_addr: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > 8'h0C |=> s_axi_rresp == 2'h2 &&
        s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
endmodule : csl_status_led_asserts
bind csl_status_led csl_status_led_asserts #(.PHASE_CYC(PHASE_CYC)) u_chk (
    .clock(clock), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .node_ready(node_ready),
    .can_warn(can_warn), .can_bus_off(can_bus_off),
    .guard_event(guard_event), .sync_timeout(sync_timeout),
    .run_led(run_led), .err_led(err_led));
`default_nettype wire

//--- dv/csl_status_led_tb.sv
`default_nettype none
module csl_status_led_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PH = 4;
    localparam int RP = 2;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF, e, r_bu, e_bu, baud_selector = 4'h3;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, clr = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, run_led, err_led, init_mode, boot_fail, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, nmt_state = 2'h2;
    logic node_ready = 0, module_fault = 0, can_warn = 0, can_bus_off = 0;
    logic guard_event = 0, sync_timeout = 0, init_run_selector = 0;
    logic [7:0] node_id_selector = 8'h05;
    logic [15:0] r_on, r_off, r_onl, r_offl, e_on, e_off, e_onl, e_offl;
    int miscompares = 0, samples_checked = 0;
    csl_pkg::csl_pat_t run_tab[4] = '{csl_pkg::PAT_SINGLE,
        csl_pkg::PAT_BLINK, csl_pkg::PAT_ON, csl_pkg::PAT_OFF};
    // clock at 125 MHz
    always #4 clock = ~clock;
    csl_status_led #(.PHASE_CYC(PH), .RAPID_CYC(RP), .GAP_CYC(10),
        .BOOT_DLY(8)) dut (.clock(clock), .arst_n(arst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .node_ready(node_ready),
        .nmt_state(nmt_state), .module_fault(module_fault),
        .can_warn(can_warn), .can_bus_off(can_bus_off),
        .guard_event(guard_event), .sync_timeout(sync_timeout),
        .baud_selector(baud_selector), .node_id_selector(node_id_selector),
        .init_run_selector(init_run_selector), .run_led(run_led),
        .err_led(err_led), .init_mode(init_mode), .boot_fail(boot_fail),
        .irq(irq));
    csl_led_watch #(.PHASE_CYC(PH)) u_run (.clock(clock), .clr(clr),
        .led(run_led), .run_on(r_on), .run_off(r_off), .on_len(r_onl),
        .off_len(r_offl), .burst(r_bu));
    csl_led_watch #(.PHASE_CYC(PH)) u_err (.clock(clock), .clr(clr),
        .led(err_led), .run_on(e_on), .run_off(e_off), .on_len(e_onl),
        .off_len(e_offl), .burst(e_bu));

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // bus write; ready is sometimes held back to stall the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw, w, rdy;
        @(posedge clock);
        aw = 0;
        w = 0;
        n = 0;
        rdy = 1'($urandom_range(1));
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= rdy;
        for (n = 0; n < 64; n++) begin
            @(posedge clock);
            if (s_axi_awready && !aw) s_axi_awvalid <= 0;
            if (s_axi_awready) aw = 1;
            if (s_axi_wready && !w) s_axi_wvalid <= 0;
            if (s_axi_wready) w = 1;
            if (s_axi_bvalid && rdy) break;
            rdy = 1;
            s_axi_bready <= 1;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 0;
        if (n >= 64) begin
            miscompares++;
            print_verdict();
        end
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        int n;
        logic ar, rdy;
        @(posedge clock);
        ar = 0;
        rdy = 1'($urandom_range(1));
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= rdy;
        for (n = 0; n < 64; n++) begin
            @(posedge clock);
            if (s_axi_arready && !ar) s_axi_arvalid <= 0;
            if (s_axi_arready) ar = 1;
            if (s_axi_rvalid && rdy) break;
            rdy = 1;
            s_axi_rready <= 1;
        end
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 0;
        if (n >= 64) begin
            miscompares++;
            print_verdict();
        end
    endtask : rdr

    task automatic rst(input logic [3:0] b, input logic [7:0] id);
        baud_selector <= b;
        node_id_selector <= id;
        arst_n <= 0;
        repeat (5) @(posedge clock);
        arst_n <= 1;
        repeat (20) @(posedge clock);
    endtask : rst

    // names a pattern from what the watcher measured
    function automatic csl_pkg::csl_pat_t cls(input logic [15:0] on, off,
        onl, offl, input logic [3:0] bu);
        if (off >= 16'h0028) return csl_pkg::PAT_OFF;
        if (on >= 16'h0028) return csl_pkg::PAT_ON;
        if (onl == 16'(RP) && offl == 16'(RP)) return csl_pkg::PAT_RAPID;
        if (onl == 16'(PH) && bu == 4'h0 && offl == 16'(PH))
            return csl_pkg::PAT_BLINK;
        if (onl == 16'(PH) && bu == 4'h1) return csl_pkg::PAT_SINGLE;
        if (onl == 16'(PH) && bu == 4'h2) return csl_pkg::PAT_DOUBLE;
        if (onl == 16'(PH) && bu == 4'h3) return csl_pkg::PAT_TRIPLE;
        return csl_pkg::csl_pat_t'(3'h7);
    endfunction : cls

    // most severe first: bus-off, sync, guarding, warning
    function automatic csl_pkg::csl_pat_t exp_err(input logic [3:0] v);
        if (v[3]) return csl_pkg::PAT_ON;
        if (v[2]) return csl_pkg::PAT_TRIPLE;
        if (v[1]) return csl_pkg::PAT_DOUBLE;
        if (v[0]) return csl_pkg::PAT_SINGLE;
        return csl_pkg::PAT_OFF;
    endfunction : exp_err

    task automatic look(input csl_pkg::csl_pat_t er, rn);
        repeat (4) @(posedge clock);
        clr <= 1;
        @(posedge clock);
        clr <= 0;
        repeat (80) @(posedge clock);
        chk("run led", 32'(cls(r_on, r_off, r_onl, r_offl, r_bu)), 32'(rn));
        chk("err led", 32'(cls(e_on, e_off, e_onl, e_offl, e_bu)), 32'(er));
    endtask : look

    initial begin
        rd = $urandom(46495);
        rst(4'h3, 8'($urandom_range(1, 127)));
        rdr(csl_pkg::CTRL_OFS);
        chk("ctrl reset", rd, csl_pkg::CTRL_RESET);
        rdr(csl_pkg::IRQ_MASK_OFS);
        chk("mask reset", rd, csl_pkg::MASK_RESET);
        rdr(8'h10);
        chk("bad read", {rd[29:0], rs}, 32'h2);
        wr(8'h14, 32'h0000_0001);
        chk("bad write", 32'(rs), 32'h2);
        node_ready <= 1;
        for (int s = 0; s < 4; s++) begin
            nmt_state <= 2'(s);
            look(csl_pkg::PAT_OFF, run_tab[s]);
        end
        nmt_state <= csl_pkg::NMT_OPER;
        node_ready <= 0;
        look(csl_pkg::PAT_OFF, csl_pkg::PAT_OFF);
        node_ready <= 1;
        for (int i = 0; i < 5; i++) begin
            e = (i == 4) ? 4'h0 : 4'(1 << i);
            {can_bus_off, sync_timeout, guard_event, can_warn} <= e;
            look(exp_err(e), csl_pkg::PAT_ON);
        end
        for (int i = 0; i < 24; i++) begin
            e = 4'($urandom);
            {can_bus_off, sync_timeout, guard_event, can_warn} <= e;
            repeat (4) @(posedge clock);
            rdr(csl_pkg::STATUS_OFS);
            chk("err code", 32'(rd[10:8]), 32'(exp_err(e)));
            chk("irq masked", 32'(irq), 32'h0);
        end
        {can_bus_off, sync_timeout, guard_event, can_warn} <= 4'h0;
        repeat (4) @(posedge clock);
        rdr(csl_pkg::IRQ_STAT_OFS);
        chk("irq events", rd, 32'h1E);
        wr(csl_pkg::IRQ_MASK_OFS, 32'h0000_0001);
        module_fault <= 1;
        @(posedge clock);
        module_fault <= 0;
        look(csl_pkg::PAT_OFF, csl_pkg::PAT_RAPID);
        chk("irq raised", 32'(irq), 32'h1);
        rdr(csl_pkg::IRQ_STAT_OFS);
        chk("irq fault", rd, 32'h1);
        repeat (3) @(posedge clock);
        chk("irq cleared", 32'(irq), 32'h0);
        look(csl_pkg::PAT_OFF, csl_pkg::PAT_RAPID);
        wr(csl_pkg::CTRL_OFS, 32'h0000_0001);
        look(csl_pkg::PAT_OFF, csl_pkg::PAT_ON);
        for (int b = 0; b < 16; b++) begin
            rst(4'(b), 8'($urandom_range(1, 127)));
            chk("init mode", 32'(init_mode), 32'(b == 9));
            chk("boot fail", 32'(boot_fail), 32'(b == 8 || b > 9));
            chk("run lit", 32'(run_led), 32'(b < 8));
        end
        rst(4'h3, 8'h80);
        chk("pair zero", 32'(boot_fail), 32'h1);
        rst(4'h3, 8'h00);
        chk("node zero", 32'(boot_fail), 32'h1);
        wr(csl_pkg::CTRL_OFS, 32'h0000_0002);
        init_run_selector <= 1;
        repeat (8) @(posedge clock);
        chk("init switch", 32'(init_mode), 32'h1);
        print_verdict();
    end
    // cut a hang short
    initial begin
        repeat (100000) @(posedge clock);
        miscompares++;
        print_verdict();
    end
endmodule : csl_status_led_tb
`default_nettype wire
